// >>> logic/bpc_map.vh
// Command codes, offsets, register map and timing counts for the buffer-program host controller
// How it works
// - Host confirms with 29h inside loaded sector; any data write starts programming
// - Commands: F0h reset, 70h@555h status enter, 71h@555h clear, AAh@555h unlock
// - While busy, B0h or 51h anywhere enters suspend-pending, keeping context
// - Suspended: 30h or 50h resumes, status view returns, clear stays suspended
// - After first unlock host writes 55h at 2AAh; anything else returns to programming
// - Second unlock: F0h completes abort reset; other writes return to programming
`ifndef BPC_MAP_VH
`define BPC_MAP_VH
`define BPC_CMD_RESET      16'h00_F0
`define BPC_CMD_SR_ENTER   16'h00_70
`define BPC_CMD_SR_CLEAR   16'h00_71
`define BPC_CMD_UNLOCK1    16'h00_AA
`define BPC_CMD_UNLOCK2    16'h00_55
`define BPC_CMD_CONFIRM    16'h00_29
`define BPC_CMD_SUSP_A     16'h00_B0
`define BPC_CMD_SUSP_B     16'h00_51
`define BPC_CMD_RESUME_A   16'h00_30
`define BPC_CMD_RESUME_B   16'h00_50
`define BPC_ADDR_UNLOCK1   26'h000_0555
`define BPC_ADDR_UNLOCK2   26'h000_02AA
// Software command register fields
`define BPC_REG_CMD        8'h00
`define BPC_REG_ADDR       8'h04
`define BPC_REG_WDATA      8'h08
`define BPC_REG_STATUS     8'h0C
`define BPC_REG_RDATA      8'h10
`define BPC_OP_WRITE       3'h1
`define BPC_OP_READ        3'h2
`define BPC_OP_CONFIRM     3'h3
`define BPC_OP_SUSPEND     3'h4
`define BPC_OP_RESUME      3'h5
`define BPC_OP_ABORT_RST   3'h6
`define BPC_OP_STATUS      3'h7
`define BPC_ST_BUSY        0
`define BPC_ST_DONE        1
`define BPC_ST_READY       7
// Bus cycle timing: write pulse, read access and recovery, 100 MHz clock
`define BPC_CLK_NS         10
`define BPC_WE_NS          35
`define BPC_WE_CYC         ((`BPC_WE_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`define BPC_RD_NS          100
`define BPC_RD_CYC         ((`BPC_RD_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`define BPC_REC_NS         20
`define BPC_REC_CYC        ((`BPC_REC_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`endif

// >>> logic/bpc_cycle.v
// One asynchronous flash bus cycle: write strobe pulse or timed read
`timescale 1ns/1ps
`include "bpc_map.vh"
module bpc_cycle (
   input  wire        core_clk,
   input  wire        rst_b,
   input  wire        clk_en,
   input  wire        start,
   input  wire        is_read,
   input  wire [25:0] addr,
   input  wire [15:0] wdata,
   output wire        done,
   output reg  [15:0] rdata_q,
   output reg  [25:0] fl_addr_q,
   output reg  [15:0] fl_dq_out_q,
   output reg         fl_dq_oe_b_q,
   input  wire [15:0] fl_dq_in,
   output reg         fl_ce_b_q,
   output reg         fl_we_b_q,
   output reg         fl_oe_b_q
);
   localparam S_IDLE = 2'd0;
   localparam S_PULSE = 2'd1;
   localparam S_REC = 2'd2;
   // Counts are loaded one short: the load edge itself is the first cycle of each phase
   localparam integer WE_LOAD  = `BPC_WE_CYC - 1;
   localparam integer RD_LOAD  = `BPC_RD_CYC - 1;
   localparam integer REC_LOAD = `BPC_REC_CYC - 1;
   reg [1:0] state_q;
   reg [3:0] cnt_q;
   reg       rd_q;
   assign done = (state_q == S_REC) && (cnt_q == 4'd0);
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q      <= S_IDLE;
         cnt_q        <= 4'd0;
         rd_q         <= 1'b0;
         rdata_q      <= 16'h0000;
         fl_addr_q    <= 26'h000_0000;
         fl_dq_out_q  <= 16'h0000;
         fl_dq_oe_b_q <= 1'b1;
         fl_ce_b_q    <= 1'b1;
         fl_we_b_q    <= 1'b1;
         fl_oe_b_q    <= 1'b1;
      end else if (clk_en) begin
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  rd_q         <= is_read;
                  fl_addr_q    <= addr;
                  fl_dq_out_q  <= wdata;
                  fl_dq_oe_b_q <= is_read;
                  fl_ce_b_q    <= 1'b0;
                  fl_we_b_q    <= is_read;
                  fl_oe_b_q    <= ~is_read;
                  cnt_q        <= is_read ? RD_LOAD[3:0] : WE_LOAD[3:0];
                  state_q      <= S_PULSE;
               end
            end
            S_PULSE: begin
               if (cnt_q != 4'd0) begin
                  cnt_q <= cnt_q - 4'd1;
               end else begin
                  // Data is latched by the device model just after the falling write strobe
                  if (rd_q) begin
                     rdata_q <= fl_dq_in;
                  end
                  fl_we_b_q <= 1'b1;
                  fl_oe_b_q <= 1'b1;
                  fl_ce_b_q <= 1'b1;
                  cnt_q     <= REC_LOAD[3:0];
                  state_q   <= S_REC;
               end
            end
            S_REC: begin
               fl_dq_oe_b_q <= 1'b1;
               if (cnt_q != 4'd0) begin
                  cnt_q <= cnt_q - 4'd1;
               end else begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule // bpc_cycle

// >>> logic/bpc_host.v
// Host controller: AHB-Lite command registers driving buffer-program command sequences
`timescale 1ns/1ps
`include "bpc_map.vh"
module bpc_host (
   input  wire        core_clk,
   input  wire        rst_b,
   input  wire        clk_en,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   output wire [25:0] fl_addr,
   output wire [15:0] fl_dq_out,
   output wire        fl_dq_oe_b,
   input  wire [15:0] fl_dq_in,
   output wire        fl_ce_b,
   output wire        fl_we_b,
   output wire        fl_oe_b,
   input  wire        fl_ready
);
   localparam H_IDLE = 3'd0;
   localparam H_CYC1 = 3'd1;
   localparam H_CYC2 = 3'd2;
   localparam H_CYC3 = 3'd3;
   localparam H_WAIT = 3'd4;

   reg  [2:0]  hst_q;
   reg  [2:0]  op_q;
   reg  [25:0] addr_q;
   reg  [15:0] wdata_q;
   reg         busy_q;
   reg         done_q;
   reg         ph_valid_q;
   reg         ph_write_q;
   reg  [7:0]  ph_addr_q;
   reg  [1:0]  step_q;
   reg  [31:0] rd_mux;
   reg         cyc_start;
   reg         cyc_read;
   reg  [25:0] cyc_addr;
   reg  [15:0] cyc_wdata;
   wire        cyc_done;
   wire [15:0] cyc_rdata;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   bpc_cycle u_cycle (
      .core_clk     (core_clk),
      .rst_b        (rst_b),
      .clk_en       (clk_en),
      .start        (cyc_start),
      .is_read      (cyc_read),
      .addr         (cyc_addr),
      .wdata        (cyc_wdata),
      .done         (cyc_done),
      .rdata_q      (cyc_rdata),
      .fl_addr_q    (fl_addr),
      .fl_dq_out_q  (fl_dq_out),
      .fl_dq_oe_b_q (fl_dq_oe_b),
      .fl_dq_in     (fl_dq_in),
      .fl_ce_b_q    (fl_ce_b),
      .fl_we_b_q    (fl_we_b),
      .fl_oe_b_q    (fl_oe_b)
   );

   // Which flash cycle each step of an operation issues
   always @* begin
      cyc_start = 1'b0;
      cyc_read  = 1'b0;
      cyc_addr  = addr_q;
      cyc_wdata = wdata_q;
      case (hst_q)
         H_CYC1: begin
            cyc_start = 1'b1;
            case (op_q)
               `BPC_OP_READ: cyc_read = 1'b1;
               `BPC_OP_CONFIRM: cyc_wdata = `BPC_CMD_CONFIRM;
               `BPC_OP_SUSPEND: cyc_wdata = `BPC_CMD_SUSP_B;
               `BPC_OP_RESUME: cyc_wdata = `BPC_CMD_RESUME_B;
               `BPC_OP_STATUS: begin
                  cyc_addr  = `BPC_ADDR_UNLOCK1;
                  cyc_wdata = `BPC_CMD_SR_ENTER;
               end
               `BPC_OP_ABORT_RST: begin
                  cyc_addr  = `BPC_ADDR_UNLOCK1;
                  cyc_wdata = `BPC_CMD_UNLOCK1;
               end
               default: cyc_start = 1'b1;
            endcase
         end
         H_CYC2: begin
            cyc_start = 1'b1;
            if (op_q == `BPC_OP_STATUS) begin
               cyc_read = 1'b1;
            end else begin
               cyc_addr  = `BPC_ADDR_UNLOCK2;
               cyc_wdata = `BPC_CMD_UNLOCK2;
            end
         end
         H_CYC3: begin
            cyc_start = 1'b1;
            cyc_addr  = `BPC_ADDR_UNLOCK1;
            cyc_wdata = `BPC_CMD_RESET;
         end
         default: cyc_start = 1'b0;
      endcase
   end

   wire bus_wr = ph_valid_q && ph_write_q;
   wire go     = bus_wr && (ph_addr_q == `BPC_REG_CMD) && !busy_q;
   // Settings are frozen while a sequence runs; hsize is not checked, only word transfers are expected
   wire wr_addr   = bus_wr && (ph_addr_q == `BPC_REG_ADDR) && !busy_q;
   wire wr_wdata  = bus_wr && (ph_addr_q == `BPC_REG_WDATA) && !busy_q;
   wire wr_status = bus_wr && (ph_addr_q == `BPC_REG_STATUS);
   wire rd_take   = hready && hsel && htrans[1] && !hwrite;
   // Sequences that need a further flash cycle after the one just finished
   wire more_abort  = (op_q == `BPC_OP_ABORT_RST) && (step_q != 2'd3);
   wire more_status = (op_q == `BPC_OP_STATUS) && (step_q == 2'd1);

   // Read data is chosen in the address phase and registered, so it stands through the data phase
   always @* begin
      rd_mux = 32'h0000_0000;
      case (haddr[7:0])
         `BPC_REG_CMD: begin
            rd_mux = {29'h0000_0000, op_q};
         end
         `BPC_REG_ADDR: begin
            rd_mux = {6'h00, addr_q};
         end
         `BPC_REG_WDATA: begin
            rd_mux = {16'h0000, wdata_q};
         end
         `BPC_REG_STATUS: begin
            rd_mux = {24'h00_0000, fl_ready, 5'h00, done_q, busy_q};
         end
         `BPC_REG_RDATA: begin
            rd_mux = {16'h0000, cyc_rdata};
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hst_q      <= H_IDLE;
         op_q       <= 3'h0;
         addr_q     <= 26'h000_0000;
         wdata_q    <= 16'h0000;
         busy_q     <= 1'b0;
         done_q     <= 1'b0;
         ph_valid_q <= 1'b0;
         ph_write_q <= 1'b0;
         ph_addr_q  <= 8'h00;
         step_q     <= 2'd0;
         hrdata     <= 32'h0000_0000;
      end else if (clk_en) begin
         if (hready) begin
            ph_valid_q <= hsel && htrans[1];
            ph_write_q <= hwrite;
            ph_addr_q  <= haddr[7:0];
         end
         if (wr_addr) begin
            addr_q <= hwdata[25:0];
         end
         if (wr_wdata) begin
            wdata_q <= hwdata[15:0];
         end
         // Done bit: write 1 clears, completion sets and wins over the clear
         if (wr_status && hwdata[`BPC_ST_DONE]) begin
            done_q <= 1'b0;
         end
         if (rd_take) begin
            hrdata <= rd_mux;
         end
         case (hst_q)
            H_IDLE: begin
               if (go && hwdata[2:0] != 3'h0) begin
                  op_q   <= hwdata[2:0];
                  busy_q <= 1'b1;
                  hst_q  <= H_CYC1;
               end
            end
            H_CYC1: begin
               step_q <= 2'd1;
               hst_q  <= H_WAIT;
            end
            H_CYC2: begin
               step_q <= 2'd2;
               hst_q  <= H_WAIT;
            end
            H_CYC3: begin
               step_q <= 2'd3;
               hst_q  <= H_WAIT;
            end
            H_WAIT: begin
               if (cyc_done) begin
                  // Step order is kept in a register rather than read back from the pins, so a user
                  // address or data word that matches a command code cannot loop the sequence
                  if (more_abort) begin
                     hst_q <= (step_q == 2'd1) ? H_CYC2 : H_CYC3;
                  end else if (more_status) begin
                     hst_q <= H_CYC2;
                  end else begin
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     hst_q  <= H_IDLE;
                  end
               end
            end
            default: hst_q <= H_IDLE;
         endcase
      end
   end
endmodule // bpc_host

// >>> bench/bpc_host_asserts.sv
// Checks on the controller's command start and flash strobes
`timescale 1ns/1ps
module bpc_host_asserts (
   input logic        core_clk,
   input logic        rst_b,
   input logic        hsel,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic [31:0] haddr,
   input logic        hready,
   input logic        fl_ce_b,
   input logic        fl_we_b,
   input logic        fl_oe_b,
   input logic        fl_dq_oe_b
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire cmd_wr = hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
   strobe_excl_a: assert property (fl_we_b || fl_oe_b)
      else $error("write and read strobes overlap");
   we_drive_a: assert property (!fl_we_b |-> !fl_ce_b && !fl_dq_oe_b)
      else $error("write strobe without select or data");
   we_pulse_a: assert property ($fell(fl_we_b) |=> !fl_we_b[*3] ##1 fl_we_b)
      else $error("write pulse not four cycles");
   oe_pulse_a: assert property ($fell(fl_oe_b) |=> !fl_oe_b[*8] ##1 !fl_oe_b ##1 fl_oe_b)
      else $error("read pulse not ten cycles");
   we_recover_a: assert property ($rose(fl_we_b) |-> (fl_we_b && fl_oe_b)[*2])
      else $error("recovery after write too short");
   cmd_start_a: assert property (cmd_wr |-> ##[1:6] !fl_ce_b)
      else $error("command did not start a flash cycle");
   read_float_a: assert property (!fl_oe_b |-> fl_dq_oe_b)
      else $error("data driven during read");
   ce_used_a: assert property ($fell(fl_ce_b) |-> ##[0:2] (!fl_we_b || !fl_oe_b))
      else $error("select without strobe");
   cover property (cmd_wr);
   cover property ($fell(fl_oe_b));
   cover property ($rose(fl_we_b) ##[1:20] $fell(fl_we_b));
endmodule // bpc_host_asserts

// >>> bench/bpc_flash_model.sv
// Behavioural flash command state machine for the buffer-program paths
`timescale 1ns/1ps
module bpc_flash_model (
   input  wire [25:0] fl_addr,
   input  wire [15:0] fl_dq_out,
   input  wire        fl_dq_oe_b,
   input  wire        fl_ce_b,
   input  wire        fl_we_b,
   input  wire        fl_oe_b,
   output wire [15:0] fl_dq_in,
   output wire        fl_ready
);
   localparam RD = 0, LC = 1, LW = 2, CF = 3, PG = 4, SUSPEND_PENDING = 5, PS = 6, U1 = 7, U2 = 8, SV = 9;
   int          st = RD, rt = RD, wc = 0, pt = 0;
   logic        baf = 0;
   logic [9:0]  sa = 0;
   logic [15:0] last = 0;
   wire       u = fl_addr == 26'h000_0555;
   wire [7:0] d = fl_dq_out[7:0];
   wire       busy = ((st == SV ? rt : st) inside {PG, SUSPEND_PENDING}) && !baf;
   assign fl_ready = !busy;
   // Released bus shows the inverse of the last value, never a held copy
   assign fl_dq_in = (!fl_oe_b && !fl_ce_b) ? (st == SV ? {8'h00, !busy, 3'b000, baf, 3'b000} : ~fl_addr[15:0]) : ~last;
   always @(fl_dq_in) if (!fl_oe_b && !fl_ce_b) last = fl_dq_in;
   always @(negedge fl_we_b) begin
      #1;
      if (!fl_ce_b) case (st)
         RD: if (d == 8'h25) begin st = LC; sa = fl_addr[25:16]; end
            else if (d == 8'h70 && u) begin rt = RD; st = SV; end
         LC: begin wc = d; st = LW; end
         LW: if (fl_addr[25:16] != sa) begin baf = 1; st = PG; end
            else if (wc == 0) st = CF;
            else wc--;
         CF: begin st = PG; pt = 200; end
         PG: if (d == 8'h70 && u) begin rt = PG; st = SV; end
            else if (busy) begin if (d == 8'hB0 || d == 8'h51) st = SUSPEND_PENDING; end
            else if (d == 8'hF0 || d == 8'h71 && u) begin st = RD; baf = 0; end
            else if (d == 8'hAA && u) st = U1;
         SUSPEND_PENDING: if (d == 8'h70 && u) begin rt = SUSPEND_PENDING; st = SV; end
         PS: if (d == 8'h30 || d == 8'h50) st = PG;
            else if (d == 8'h70 && u) begin rt = PS; st = SV; end
         U1: st = (fl_addr == 26'h000_02AA && d == 8'h55) ? U2 : PG;
         U2: if (d == 8'hF0) begin st = RD; baf = 0; end else st = PG;
         default: ;
      endcase
   end
   always @(posedge fl_oe_b) if (st == SV) st = rt;
   always #10 if (st == PG && !baf) if (pt == 0) st = RD; else pt--;
   // A status view open at the deadline still lands the suspend, it just returns to suspended
   always @(st) if (st == SUSPEND_PENDING) #200 if (st == SUSPEND_PENDING) st = PS; else if (st == SV && rt == SUSPEND_PENDING) rt = PS;
endmodule // bpc_flash_model

// >>> bench/tb_bpc_host.sv
// Self-checking bench for the buffer-program host controller
`timescale 1ns/1ps
module tb_bpc_host;
   logic        core_clk = 0, rst_b = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, q;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'b010;
   wire         hreadyout, hresp, fl_dq_oe_b, fl_ce_b, fl_we_b, fl_oe_b, fl_ready;
   wire [31:0]  hrdata;
   wire [25:0]  fl_addr;
   wire [15:0]  fl_dq_out, fl_dq_in;
   int          fails = 0, comparisons = 0;
   bpc_host dut (.core_clk, .rst_b, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fl_addr, .fl_dq_out, .fl_dq_oe_b, .fl_dq_in,
      .fl_ce_b, .fl_we_b, .fl_oe_b, .fl_ready);
   bpc_flash_model m (.fl_addr, .fl_dq_out, .fl_dq_oe_b, .fl_ce_b, .fl_we_b, .fl_oe_b, .fl_dq_in, .fl_ready);
   initial forever #5 core_clk = ~core_clk;
   task check(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0000_00, a};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'b00; hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   // Clearing done first keeps a stale done from ending the wait early
   task op(input logic [2:0] c, input logic [25:0] a, input logic [15:0] d);
      bus(1, 8'h0C, 32'h0000_0002);
      bus(1, 8'h04, {6'h00, a});
      bus(1, 8'h08, {16'h0000, d});
      bus(1, 8'h00, {29'h0000_0000, c});
      do bus(0, 8'h0C, 0); while (q[1] !== 1'b1);
   endtask
   task t_status;
      op(7, 26'h000_0555, 0);
      bus(0, 8'h10, 0); check(q[15:0], 16'h0080);
      check(m.st, 0);
      bus(0, 8'h0C, 0); check(q[7], 1'b1);
      bus(0, 8'h20, 0); check(q, 0);
   endtask
   task t_prog;
      op(1, 26'h001_0000, 16'h0025); op(1, 26'h001_0000, 16'h0001);
      op(1, 26'h001_0004, 16'h1234); check(m.st, 2);
      op(1, 26'h001_0005, 16'h5678); check(m.st, 3);
      op(3, 26'h001_0000, 0); check(m.st, 4);
      op(7, 26'h001_0000, 0); bus(0, 8'h10, 0); check(q[15:0], 0);
      check(m.st, 4);
      op(4, 0, 0); check(m.st, 5);
      repeat (30) @(posedge core_clk);
      check(m.st, 6);
      op(7, 0, 0); bus(0, 8'h10, 0); check(q[15:0], 16'h0080);
      check(m.st, 6);
      op(5, 0, 0); check(m.st, 4);
      do bus(0, 8'h0C, 0); while (q[7] !== 1'b1);
      check(m.st, 0);
   endtask
   task t_abort;
      op(1, 26'h002_0000, 16'h0025); op(1, 26'h002_0000, 16'h0003);
      op(1, 26'h003_0000, 16'h0001); check(m.st, 4);
      op(7, 26'h002_0000, 0); bus(0, 8'h10, 0); check(q[15:0], 16'h0088);
      op(6, 0, 0); check(m.st, 0);
   endtask
   task final_report;
      if (fails == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1;
      @(posedge core_clk);
      t_status;
      t_prog;
      t_abort;
      final_report;
   end
   initial begin
      #200000;
      fails++;
      final_report;
   end
endmodule // tb_bpc_host
bind bpc_host bpc_host_asserts chk (.core_clk, .rst_b, .hsel, .htrans, .hwrite, .haddr, .hready,
   .fl_ce_b, .fl_we_b, .fl_oe_b, .fl_dq_oe_b);
